// ===== asp2_pkg.sv
// Shared constants for the second asynchronous serial port
package asp2_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CTRL_STAT = 12'hf98; // Control write, status read
    localparam logic [11:0] IDX_DATA = 12'hf9a; // Tx buffer write, rx buffer read

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_TXE = 7;
    localparam int CTL_RXE = 6;
    localparam int CTL_STOP2 = 5;
    localparam int CTL_EVEN = 4;
    localparam int CTL_PE = 3;
    localparam int CTL_BAUD_HI = 2;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ST_PARITY_ERROR_FLAG = 7;
    localparam int ST_FRAMING_ERROR_FLAG = 6;
    localparam int ST_OVERRUN_FLAG = 5;
    localparam int ST_RX_BUFFER_FULL_FLAG = 4;
    localparam int ST_TX_DONE_FLAG = 3;
    localparam int ST_TX_BUFFER_EMPTY_FLAG = 2;

    // ------------------------------------------------------------
    // Baud select codes and phase divisors of the clock for both directions
    // ------------------------------------------------------------
    localparam logic [2:0] BAUD_TIMER = 3'h6;
    localparam logic [8:0] DIV_0 = 9'h00d; // fc/13
    localparam logic [8:0] DIV_1 = 9'h01a; // fc/26
    localparam logic [8:0] DIV_2 = 9'h034; // fc/52
    localparam logic [8:0] DIV_3 = 9'h068; // fc/104
    localparam logic [8:0] DIV_4 = 9'h0d0; // fc/208
    localparam logic [8:0] DIV_5 = 9'h1a0; // fc/416
    localparam logic [8:0] DIV_7 = 9'h060; // fc/96

    // ------------------------------------------------------------
    // Bit timing in phase ticks
    // ------------------------------------------------------------
    localparam logic [3:0] PH_S1 = 4'h7;
    localparam logic [3:0] PH_S2 = 4'h8;
    localparam logic [3:0] PH_S3 = 4'h9;
    localparam logic [3:0] PH_LAST = 4'hf;
    localparam logic [3:0] RX_LAST_DATA = 4'h8;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== asp2_top.sv
// Second asynchronous serial port with an AXI4-Lite register slave
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
// What this block does
// R1: Idle receiver samples input watching for low start
// R2: Sample each bit at phases seven, eight, nine
// R3: Bit value is majority of three samples
// R4: Transmitter sends one or two stop bits
// R5: Parity added and checked only when enabled
// R6: Software enables, reads status, then writes buffer
// R7: Accepted buffer write clears empty, starts shifting
// R8: Frame: low start, data, parity, high stops
// R9: Transmit start sets empty flag, pulses interrupt
// R10: Output stays high until enabled and written
// R11: Write without status read is ignored
// R12: Stop received: load data, set full, interrupt
// R13: Frame into full buffer sets overrun, discarded
// R14: No reception starts while overrun is set
// R15: Receive disable waits for frame in progress
// R16: Parity mismatch sets parity error flag
// R17: Low stop sample sets framing error flag
// R18: Status then buffer read clears receive flags
// R19: Software rereads status to check overrun
// R20: Transmit end set when idle, cleared on start
// R21: One baud select drives transmit and receive
// R22: Software disables both before changing baud
// R23: Timer pulse is phase clock, baud is sixteenth
// R24: Eight data bits, least significant first
module asp2_top #(
    parameter int AW = 16
) (
    // Clock, reset and clock enable
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // AXI4-Lite write address and data
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Serial pins and timer pulse
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin,
    input wire logic i_baud_timer,
    // Event pulses
    output logic o_tx_interrupt,
    output logic o_rx_interrupt
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Word index match for a register
    function automatic logic is_idx(input logic [AW-1:0] a,
                                    input logic [11:0] idx);
        is_idx = (a[AW-1:2] == (AW-2)'(idx));
    endfunction

    // Majority of three samples
    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Phase divisor for a baud select code
    function automatic logic [8:0] div_of(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_of = asp2_pkg::DIV_0;
            3'h1: div_of = asp2_pkg::DIV_1;
            3'h2: div_of = asp2_pkg::DIV_2;
            3'h3: div_of = asp2_pkg::DIV_3;
            3'h4: div_of = asp2_pkg::DIV_4;
            3'h5: div_of = asp2_pkg::DIV_5;
            3'h6: div_of = asp2_pkg::DIV_0; // Unused, timer drives
            3'h7: div_of = asp2_pkg::DIV_7;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_q; // serial_control_one
    logic aw_full_q, w_full_q; // Latched write halves
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go, rd_go; // Write executes, read taken
    logic st_rd, rx_rd, tx_wr; // Register side effects
    logic seen_q; // Status read seen since last data access
    logic tick_q; // Phase clock pulse for both directions
    logic [8:0] div_cnt_q;
    logic tx_busy_q, tx_start, tx_end;
    logic [11:0] tx_frame_q;
    logic [3:0] tx_bits_q, tx_ph_q;
    logic [7:0] tx_hold_q; // tx_holding_buffer
    logic tx_buffer_empty_flag_q, tx_done_flag_q;
    logic rx_busy_q, rx_start, rx_done_q, rx_parity_error_flag_q, rx_framing_error_flag_q;
    logic [3:0] rx_ph_q, rx_idx_q;
    logic rx_s7_q, rx_s8_q, rx_bit, rx_parbit_q;
    logic [7:0] rx_shift_q;
    logic [7:0] rx_buf_q; // rx_holding_buffer
    logic rx_buffer_full_flag_q, overrun_flag_q, parity_error_flag_q, framing_error_flag_q;
    logic rx_clear, rx_load;
    logic [7:0] status;

    // ------------------------------------------------------------
    // Bus write channel
    // ------------------------------------------------------------
    assign wr_go = aw_full_q & w_full_q & ~o_bvalid;

    // Address and data are taken independently, in either order
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            o_bvalid <= 1'b0;
            o_bresp <= asp2_pkg::RESP_OKAY;
        end else if (i_ce) begin
            // Ready is a one-cycle pulse; the master holds valid
            o_awready <= i_awvalid & ~o_awready & ~aw_full_q;
            o_wready <= i_wvalid & ~o_wready & ~w_full_q;
            if (i_awvalid & o_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (i_wvalid & o_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
            if (wr_go) begin
                o_bvalid <= 1'b1;
                o_bresp <= (is_idx(awaddr_q, asp2_pkg::IDX_CTRL_STAT) ||
                            is_idx(awaddr_q, asp2_pkg::IDX_DATA)) ?
                           asp2_pkg::RESP_OKAY : asp2_pkg::RESP_SLVERR;
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Control register; only the low byte lane carries bits
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= asp2_pkg::CTL_RESET;
        end else if (i_ce && wr_go && wstrb_q[0] &&
                     is_idx(awaddr_q, asp2_pkg::IDX_CTRL_STAT)) begin
            ctrl_q <= wdata_q[7:0];
        end
    end

    // ------------------------------------------------------------
    // Bus read channel
    // ------------------------------------------------------------
    assign rd_go = i_arvalid & o_arready;
    assign st_rd = rd_go & is_idx(i_araddr, asp2_pkg::IDX_CTRL_STAT);
    assign rx_rd = rd_go & is_idx(i_araddr, asp2_pkg::IDX_DATA);
    assign tx_wr = wr_go & wstrb_q[0] &
                   is_idx(awaddr_q, asp2_pkg::IDX_DATA);
    assign status = {parity_error_flag_q, framing_error_flag_q, overrun_flag_q, rx_buffer_full_flag_q, tx_done_flag_q, tx_buffer_empty_flag_q,
                     2'h0};

    // Read data is captured at the address handshake
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= asp2_pkg::RESP_OKAY;
        end else if (i_ce) begin
            o_arready <= i_arvalid & ~o_arready & ~o_rvalid;
            if (rd_go) begin
                o_rvalid <= 1'b1;
                o_rresp <= asp2_pkg::RESP_OKAY;
                if (st_rd) begin
                    o_rdata <= {24'h000000, status};
                end else if (rx_rd) begin
                    o_rdata <= {24'h000000, rx_buf_q};
                end else begin
                    // Unmapped word reads as zero with an error
                    o_rdata <= '0;
                    o_rresp <= asp2_pkg::RESP_SLVERR;
                end
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Status read arms the next data access; a data access disarms
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seen_q <= 1'b0;
        end else if (i_ce) begin
            if (st_rd) begin
                seen_q <= 1'b1;
            end else if (rx_rd | (wr_go &
                         is_idx(awaddr_q, asp2_pkg::IDX_DATA))) begin
                seen_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase clock, shared by both directions
    // ------------------------------------------------------------
    // Sixteen ticks per bit; the timer pulse is taken directly
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (i_ce) begin
            if (ctrl_q[asp2_pkg::CTL_BAUD_HI:0] == asp2_pkg::BAUD_TIMER)
            begin
                tick_q <= i_baud_timer; // R23
                div_cnt_q <= '0;
            end else if (div_cnt_q >=
                         div_of(ctrl_q[asp2_pkg::CTL_BAUD_HI:0]) - 9'h001)
            begin
                div_cnt_q <= '0;
                tick_q <= 1'b1; // R21
            end else begin
                div_cnt_q <= div_cnt_q + 9'h001;
                tick_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    // Disable only blocks the next start, so a frame always ends
    assign tx_start = ~tx_busy_q & ~tx_buffer_empty_flag_q & ctrl_q[asp2_pkg::CTL_TXE];
    assign tx_end = tx_busy_q & tick_q & (tx_ph_q == asp2_pkg::PH_LAST) &
                    (tx_bits_q == 4'h1);

    // Frame shifter; the pin idles high
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_busy_q <= 1'b0;
            tx_frame_q <= '1;
            tx_bits_q <= '0;
            tx_ph_q <= '0;
            o_serial_out_pin <= 1'b1;
        end else if (i_ce) begin
            if (tx_start) begin
                tx_busy_q <= 1'b1; // R7
                tx_ph_q <= '0;
                o_serial_out_pin <= 1'b0; // R8
                tx_bits_q <= 4'ha + {3'h0, ctrl_q[asp2_pkg::CTL_PE]} +
                             {3'h0, ctrl_q[asp2_pkg::CTL_STOP2]}; // R4
                if (ctrl_q[asp2_pkg::CTL_PE]) begin
                    tx_frame_q <= {2'h3, ^tx_hold_q ^
                                   ~ctrl_q[asp2_pkg::CTL_EVEN],
                                   tx_hold_q, 1'b0}; // R5
                end else begin
                    tx_frame_q <= {3'h7, tx_hold_q, 1'b0}; // R24
                end
            end else if (tx_busy_q && tick_q) begin
                tx_ph_q <= tx_ph_q + 4'h1;
                if (tx_ph_q == asp2_pkg::PH_LAST) begin
                    tx_frame_q <= {1'b1, tx_frame_q[11:1]}; // R24
                    tx_bits_q <= tx_bits_q - 4'h1;
                    o_serial_out_pin <= tx_end | tx_frame_q[1];
                    if (tx_end) begin
                        tx_busy_q <= 1'b0; // R10
                    end
                end
            end
        end
    end

    // Holding buffer, empty and end flags, transmit event
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_hold_q <= '0;
            tx_buffer_empty_flag_q <= 1'b1;
            tx_done_flag_q <= 1'b1;
            o_tx_interrupt <= 1'b0;
        end else if (i_ce) begin
            o_tx_interrupt <= tx_start; // R9
            if (tx_wr && seen_q && tx_buffer_empty_flag_q) begin
                tx_hold_q <= wdata_q[7:0];
                tx_buffer_empty_flag_q <= 1'b0; // R7 R11
            end else if (tx_start) begin
                tx_buffer_empty_flag_q <= 1'b1; // R9
            end
            if (tx_start) begin
                tx_done_flag_q <= 1'b0; // R20
            end else if (tx_end && tx_buffer_empty_flag_q) begin
                tx_done_flag_q <= 1'b1; // R20
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    // Enable and overrun are looked at only when a frame starts
    assign rx_start = ~rx_busy_q & tick_q & ~i_serial_in_pin &
                      ctrl_q[asp2_pkg::CTL_RXE] & ~overrun_flag_q; // R1 R14 R15
    assign rx_bit = maj3(rx_s7_q, rx_s8_q, i_serial_in_pin); // R3

    // Bit sampler; the detecting tick counts as phase zero
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_busy_q <= 1'b0;
            rx_ph_q <= '0;
            rx_idx_q <= '0;
            rx_s7_q <= 1'b1;
            rx_s8_q <= 1'b1;
            rx_shift_q <= '0;
            rx_parbit_q <= 1'b0;
            rx_done_q <= 1'b0;
            rx_parity_error_flag_q <= 1'b0;
            rx_framing_error_flag_q <= 1'b0;
        end else if (i_ce) begin
            rx_done_q <= 1'b0;
            if (rx_start) begin
                rx_busy_q <= 1'b1;
                rx_ph_q <= 4'h1;
                rx_idx_q <= '0;
            end else if (rx_busy_q && tick_q) begin
                rx_ph_q <= rx_ph_q + 4'h1;
                if (rx_ph_q == asp2_pkg::PH_S1) begin
                    rx_s7_q <= i_serial_in_pin; // R2
                end
                if (rx_ph_q == asp2_pkg::PH_S2) begin
                    rx_s8_q <= i_serial_in_pin; // R2
                end
                if (rx_ph_q == asp2_pkg::PH_LAST) begin
                    rx_idx_q <= rx_idx_q + 4'h1;
                end
                if (rx_ph_q == asp2_pkg::PH_S3) begin // R2
                    if (rx_idx_q == 4'h0) begin
                        // A high start bit was a glitch
                        rx_busy_q <= rx_bit ? 1'b0 : 1'b1;
                    end else if (rx_idx_q <= asp2_pkg::RX_LAST_DATA) begin
                        rx_shift_q <= {rx_bit, rx_shift_q[7:1]}; // R24
                    end else if (rx_idx_q == 4'h9 &&
                                 ctrl_q[asp2_pkg::CTL_PE]) begin
                        rx_parbit_q <= rx_bit; // R5
                    end else begin
                        // First stop bit ends the frame early, so
                        // the next start edge is never missed
                        rx_busy_q <= 1'b0;
                        rx_done_q <= 1'b1;
                        rx_framing_error_flag_q <= ~rx_bit; // R17
                        rx_parity_error_flag_q <= ctrl_q[asp2_pkg::CTL_PE] &
                                     (^rx_shift_q ^
                                      ~ctrl_q[asp2_pkg::CTL_EVEN] ^
                                      rx_parbit_q); // R16
                    end
                end
            end
        end
    end

    // Receive buffer and flags; a new event beats a same-cycle clear
    assign rx_clear = rx_rd & seen_q;
    assign rx_load = rx_done_q & (~rx_buffer_full_flag_q | rx_clear);
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_buf_q <= '0;
            rx_buffer_full_flag_q <= 1'b0;
            overrun_flag_q <= 1'b0;
            parity_error_flag_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            o_rx_interrupt <= 1'b0;
        end else if (i_ce) begin
            o_rx_interrupt <= rx_load; // R12
            if (rx_load) begin
                rx_buf_q <= rx_shift_q; // R12
                rx_buffer_full_flag_q <= 1'b1;
                parity_error_flag_q <= rx_parity_error_flag_q; // R16
                framing_error_flag_q <= rx_framing_error_flag_q; // R17
            end else if (rx_clear) begin
                rx_buffer_full_flag_q <= 1'b0; // R18
                parity_error_flag_q <= 1'b0;
                framing_error_flag_q <= 1'b0;
            end
            if (rx_done_q && !rx_load) begin
                overrun_flag_q <= 1'b1; // R13
            end else if (rx_clear) begin
                overrun_flag_q <= 1'b0; // R18
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_tx_idle_high;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !tx_busy_q |-> o_serial_out_pin;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) // R10
        else $error("Output low while transmitter idle");

    property p_start_low;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && tx_start) |=> !o_serial_out_pin && tx_buffer_empty_flag_q && !tx_done_flag_q;
    endproperty
    a_start_low: assert property (p_start_low) // R8
        else $error("Start bit or flags wrong at transmit start");

    property p_tx_irq;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && tx_start) |=> o_tx_interrupt;
    endproperty
    a_tx_irq: assert property (p_tx_irq) // R9
        else $error("No transmit event at start");

    property p_unarmed_write;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && tx_wr && !seen_q && tx_buffer_empty_flag_q) |=> tx_buffer_empty_flag_q;
    endproperty
    a_unarmed_write: assert property (p_unarmed_write) // R11
        else $error("Unarmed write cleared empty flag");

    property p_rx_load;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && rx_done_q && !rx_buffer_full_flag_q) |=>
            rx_buffer_full_flag_q && o_rx_interrupt && rx_buf_q == $past(rx_shift_q);
    endproperty
    a_rx_load: assert property (p_rx_load) // R12
        else $error("Received byte not loaded");

    property p_overrun;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && rx_done_q && rx_buffer_full_flag_q && !rx_clear) |=>
            overrun_flag_q && $stable(rx_buf_q);
    endproperty
    a_overrun: assert property (p_overrun) // R13
        else $error("Overrun not flagged or buffer changed");

    property p_no_rx_overrun;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && overrun_flag_q && !rx_busy_q) |=> !rx_busy_q;
    endproperty
    a_no_rx_overrun: assert property (p_no_rx_overrun) // R14
        else $error("Reception started during overrun");

    property p_clear;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && rx_clear && !rx_done_q) |=>
            !rx_buffer_full_flag_q && !overrun_flag_q && !parity_error_flag_q && !framing_error_flag_q;
    endproperty
    a_clear: assert property (p_clear) // R18
        else $error("Receive flags not cleared");

    property p_tx_frame_len;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && tx_start && ctrl_q[asp2_pkg::CTL_PE] &&
         ctrl_q[asp2_pkg::CTL_STOP2]) |=> tx_bits_q == 4'hc;
    endproperty
    a_tx_frame_len: assert property (p_tx_frame_len) // R4
        else $error("Wrong frame length for two stop bits");

    c_tx_frame: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        tx_end);
    c_rx_frame: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        rx_load);
    c_overrun: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        rx_done_q && !rx_load);

endmodule // asp2_top

// ===== asp2_peer.sv
// Far-end serial peer: sends frames to the port and captures its frames
`timescale 1ns/100ps
module asp2_peer (
    // Clock and serial lines
    input wire logic i_mclk,
    input wire logic i_line,
    output logic o_line
);
    int bt = 208; // Cycles per bit, set by the bench to match the baud
    initial o_line = 1'b1;
    // Bits go out first-bit-first; a short last bit models a cut stop
    task automatic send(input logic [11:0] f, input int n, input int cut);
        for (int i = 0; i < n; i++) begin
            @(posedge i_mclk) o_line <= f[i];
            repeat (((i == n - 1) ? cut : bt) - 1) @(posedge i_mclk);
        end
        o_line <= 1'b1; // Back to idle high so no false start is seen
    endtask
    // Wait for a start level and sample each bit near its middle
    task automatic grab(input int n, output logic [11:0] f);
        f = '0;
        while (i_line !== 1'b0) @(posedge i_mclk);
        repeat (bt / 2) @(posedge i_mclk);
        for (int i = 0; i < n; i++) begin
            f[i] = i_line;
            repeat (bt) @(posedge i_mclk);
        end
    endtask
endmodule // asp2_peer

// ===== asp2_top_tb.sv
// Self-checking bench for the second asynchronous serial port
`timescale 1ns/100ps
module asp2_top_tb;
    // Bus, serial and event signals
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic tmr = 0, line, tx, txi, rxi, awr, wrr, bv, arr, rv;
    logic [1:0] br, rr, rs, tc = 0;
    logic [15:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdata, v;
    logic [11:0] f;
    int n_errors = 0, check_count = 0, n_txi = 0, n_rxi = 0;
    localparam logic [15:0] A_CS = {2'h0, asp2_pkg::IDX_CTRL_STAT, 2'h0};
    localparam logic [15:0] A_DT = {2'h0, asp2_pkg::IDX_DATA, 2'h0};
    always #5 clk = ~clk;
    asp2_top uut (.i_mclk(clk), .i_rst_b(rst_b), .i_ce(1'b1),
        .i_awaddr(aw), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
        .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr), .o_bresp(br),
        .o_bvalid(bv), .i_bready(bry), .i_araddr(ar), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(rry), .i_serial_in_pin(line), .o_serial_out_pin(tx),
        .i_baud_timer(tmr), .o_tx_interrupt(txi), .o_rx_interrupt(rxi));
    asp2_peer peer (.i_mclk(clk), .i_line(tx), .o_line(line));
    // Timer pulse every fourth cycle, so a timer-clocked bit is 64 cycles
    always @(posedge clk) begin
        tc <= tc + 2'h1;
        tmr <= (tc == 2'h0);
        n_txi += (txi === 1'b1);
        n_rxi += (rxi === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Write: both halves offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        aw <= a;
        wd <= {24'h0, d};
        {awv, wv, bry} <= 3'h7;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        rs = br;
        // Let an edge pass so the next call never re-raises at once
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        ar <= a;
        {arv, rry} <= 2'h3;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        d = rdata;
        rs = rr;
        @(posedge clk);
    endtask
    // Reset values; the data read also disarms the write path
    task automatic t_reset();
        rd(A_CS, v);
        chk("status", v, 32'h0c);
        chk("txpin", tx, 1'b1);
        rd(A_DT, v);
        chk("rxbuf", v, 32'h0);
        rd(16'h0004, v);
        chk("rresp", rs, asp2_pkg::RESP_SLVERR);
        wr(16'h0004, 8'h00);
        chk("bresp", rs, asp2_pkg::RESP_SLVERR);
    endtask
    // Plain, odd parity with two stops, and timer-clocked frames
    task automatic t_tx();
        logic [7:0] c [3] = '{8'h80, 8'ha8, 8'h86};
        logic [7:0] d;
        logic [11:0] e;
        int k;
        for (int i = 0; i < 3; i++) begin
            d = 8'ha5 + 8'(i);
            peer.bt = (i == 2) ? 64 : 208;
            wr(A_CS, c[i]);
            wr(A_DT, 8'h5a);
            repeat (20) @(posedge clk);
            chk("idle", tx, 1'b1);
            rd(A_CS, v);
            chk("tx_buffer_empty_flag", v, 32'h0c);
            k = n_txi;
            wr(A_DT, d);
            rd(A_CS, v);
            chk("started", v, 32'h04);
            peer.grab((i == 1) ? 12 : 10, f);
            e = (i == 1) ? {2'h3, ~^d, d, 1'b0} : {3'h1, d, 1'b0};
            chk("frame", f, e);
            chk("txint", n_txi, k + 1);
            rd(A_CS, v);
            chk("tx_done_flag", v, 32'h0c);
            rd(A_DT, v);
            wr(A_CS, 8'h00);
        end
    endtask
    // Load, overrun into a full buffer, then parity and framing errors
    task automatic t_rx();
        peer.bt = 208;
        wr(A_CS, 8'h58);
        peer.send(12'h478, 11, 208);
        repeat (30) @(posedge clk);
        rd(A_CS, v);
        chk("full", v, 32'h1c);
        chk("rxint", n_rxi, 1);
        peer.send(12'h502, 11, 208);
        repeat (30) @(posedge clk);
        rd(A_CS, v);
        chk("overrun", v, 32'h3c);
        rd(A_DT, v);
        chk("kept", v, 32'h3c);
        rd(A_CS, v);
        chk("cleared", v, 32'h0c);
        peer.send(12'h278, 11, 150);
        repeat (300) @(posedge clk);
        rd(A_CS, v);
        chk("parity_error_flag_framing_error_flag", v, 32'hdc);
        rd(A_DT, v);
        rd(A_CS, v);
        chk("clr_err", v, 32'h0c);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        test_done();
    end
    // Watchdog well beyond the roughly 13000 cycles the tests take
    initial begin
        #1000000;
        n_errors++;
        test_done();
    end
endmodule // asp2_top_tb
